// File: design/uefr_consts.svh
// Offsets, field positions, reset values and timing for the USB event flag block
`ifndef UEFR_CONSTS_SVH
`define UEFR_CONSTS_SVH

// ==========================================
// Register byte offsets
`define UEFR_OFS_FLAGS      8'h00
`define UEFR_OFS_ENABLES    8'h04
`define UEFR_OFS_ERR_EN     8'h08
`define UEFR_OFS_ERR_FLAGS  8'h0c
`define UEFR_OFS_CONTROL    8'h10
`define UEFR_OFS_XFER_STAT  8'h14
`define UEFR_OFS_FUNC_ADDR  8'h18
`define UEFR_OFS_FLAG_CLR   8'h1c

// ==========================================
// Event flag bit positions
`define UEFR_B_SOF    6
`define UEFR_B_STALL  5
`define UEFR_B_IDLE   4
`define UEFR_B_TRN    3
`define UEFR_B_ACTV   2
`define UEFR_B_UERR   1
`define UEFR_B_URST   0
`define UEFR_FLAG_W   7

// ==========================================
// Control, address and reset values
`define UEFR_CTRL_SUSPEND  1
`define UEFR_CTRL_W        8
`define UEFR_FADDR_W       7
`define UEFR_ZERO7         7'h00
`define UEFR_ZERO8         8'h00
`define UEFR_ZERO32        32'h0000_0000

// ==========================================
// Timing
`define UEFR_CLK_MHZ       100
`define UEFR_IDLE_TIME_US  3000

`endif

// File: design/uefr_pkg.sv
// Types shared by the USB event flag block
package uefr_pkg;

  // ==========================================
  // Data types
  typedef logic [6:0] uefr_flags_type;   // Seven implemented flag bits
  typedef logic [7:0] uefr_byte_type;    // One register byte

  // ==========================================
  // Idle detector states, Gray along busy -> counting -> seen
  typedef enum logic [1:0] {
    UEFR_IDLE_BUSY  = 2'b00,
    UEFR_IDLE_COUNT = 2'b01,
    UEFR_IDLE_SEEN  = 2'b11
  } uefr_idle_type;

endpackage : uefr_pkg

// File: design/uefr_stat_queue.sv
// Transfer status queue: completed-transaction records waiting for software
`include "uefr_consts.svh"

module uefr_stat_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  // Filling side
  input  wire logic                       push_i,
  input  wire logic [WIDTH-1:0]           data_i,
  output logic                            ready_o,
  // Draining side
  input  wire logic                       pop_i,
  output logic [WIDTH-1:0]                head_o,
  output logic [$clog2(DEPTH+1)-1:0]      count_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  // ==========================================
  // Storage
  logic [WIDTH-1:0] mem_r [DEPTH];   // Status records
  logic [PW-1:0]    wr_ptr_r;        // Next slot to fill
  logic [PW-1:0]    rd_ptr_r;        // Oldest record
  logic [CW-1:0]    count_r;         // Records held
  logic             do_push;         // Accepted push
  logic             do_pop;          // Accepted pop

  assign do_push = push_i && (count_r != CW'(DEPTH));
  assign do_pop  = pop_i && (count_r != '0);
  assign head_o  = mem_r[rd_ptr_r];
  assign count_o = count_r;

  // Record write; storage needs no reset
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= data_i;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Fill level and registered ready, so the source sees back-pressure
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_r <= '0;
      ready_o <= 1'b1;
    end else begin
      count_r <= count_r + CW'(do_push) - CW'(do_pop);
      ready_o <= (count_r + CW'(do_push) - CW'(do_pop)) != CW'(DEPTH);
    end
  end

  // ==========================================
  // Checks
  a_queue_bound: assert property (@(posedge clk_i) disable iff (reset_i)
    count_r <= CW'(DEPTH))
    else $error("status queue holds more than its depth");

endmodule : uefr_stat_queue

// File: design/uefr_top.sv
// USB event flag register bank with interrupt request and Wishbone slave
//
// How it works
// - Each event flag has its own enable bit
// - All flags ORed into one request
// - Engine-set flags stay until software writes zero, or writes one at the clear offset
// - Software writing one sets a flag
// - Suspend blocks every event except bus activity and the done re-raise after a pop
// - STALL handshake sent sets stall flag
// - Three milliseconds continuous idle sets idle flag
// - Completed transaction sets done flag, status readable
// - D+/D- activity sets flag, even when suspended
// - Only enabled error conditions raise error summary
// - Error summary ignores flag register writes; clearing latched errors drops it
// - Bus reset sets flag, zeroes function address
`include "uefr_consts.svh"

module uefr_top #(
  parameter int IDLE_CYCLES = `UEFR_IDLE_TIME_US * `UEFR_CLK_MHZ,
  parameter int QUEUE_DEPTH = 4
) (
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_I,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Serial engine events
  input  wire logic        SOF_EVT_I,
  input  wire logic        STALL_SENT_I,
  input  wire logic        BUS_IDLE_I,
  input  wire logic        TRN_DONE_I,
  input  wire logic [7:0]  TRN_STAT_I,
  output logic             TRN_READY_O,
  input  wire logic        BUS_RESET_I,
  input  wire logic [7:0]  ERR_EVT_I,
  // Bus lines for activity detection
  input  wire logic        LINE_DP_I,
  input  wire logic        LINE_DM_I,
  // Engine control
  output logic             SUSPEND_O,
  output logic [6:0]       FUNC_ADDR_O,
  // Interrupts
  output logic             USB_IRQ_REQ_O,
  output logic             IRQ_O
);

  localparam int IW = $clog2(IDLE_CYCLES + 1);
  localparam int CW = $clog2(QUEUE_DEPTH + 1);

  // ==========================================
  // Declarations
  uefr_pkg::uefr_flags_type flags_r;        // Event flags
  uefr_pkg::uefr_flags_type flags_nxt;      // Next event flags
  uefr_pkg::uefr_flags_type enables_r;      // Per-flag enables
  uefr_pkg::uefr_flags_type hw_set;         // Hardware set requests
  uefr_pkg::uefr_flags_type sw_set;         // Software set mask
  uefr_pkg::uefr_flags_type sw_clr;         // Software clear mask
  uefr_pkg::uefr_byte_type  err_en_r;       // Error condition enables
  uefr_pkg::uefr_byte_type  err_flags_r;    // Latched enabled errors
  uefr_pkg::uefr_byte_type  control_r;      // Engine control
  uefr_pkg::uefr_idle_type  idle_state_r;   // Idle detector state
  logic [IW-1:0]            idle_cnt_r;     // Idle cycles seen
  logic                     idle_hit;       // Idle time reached
  logic                     susp;           // Engine unclocked
  logic                     lines_dp_r;     // Previous D+ sample
  logic                     lines_dm_r;     // Previous D- sample
  logic                     lines_ok_r;     // Previous sample valid
  logic                     actv_evt;       // Line change seen
  logic                     req;            // New bus request
  logic                     wr_fire;        // Write takes effect now
  logic                     wr_flags;       // Write to flag register
  logic                     wr_clr;         // Write to clear register
  logic                     trn_push;       // Record a completion
  logic                     trn_pop;        // Software acknowledged
  logic [7:0]               q_head;         // Oldest status record
  logic [CW-1:0]            q_count;        // Records waiting
  logic [7:0]               rd_byte;        // Read mux result

  // ==========================================
  // Wishbone decode
  assign susp     = control_r[`UEFR_CTRL_SUSPEND];
  assign req      = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // Write lands on the edge where the master sees ack
  assign wr_fire  = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
  assign wr_flags = wr_fire && (WB_ADR_I == `UEFR_OFS_FLAGS);
  assign wr_clr   = wr_fire && (WB_ADR_I == `UEFR_OFS_FLAG_CLR);

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (WB_ADR_I)
      `UEFR_OFS_FLAGS:     rd_byte = {1'b0, flags_r};
      `UEFR_OFS_ENABLES:   rd_byte = {1'b0, enables_r};
      `UEFR_OFS_ERR_EN:    rd_byte = err_en_r;
      `UEFR_OFS_ERR_FLAGS: rd_byte = err_flags_r;
      `UEFR_OFS_CONTROL:   rd_byte = control_r;
      `UEFR_OFS_XFER_STAT: rd_byte = (q_count != '0) ? q_head : `UEFR_ZERO8;
      `UEFR_OFS_FUNC_ADDR: rd_byte = {1'b0, FUNC_ADDR_O};
      default:             rd_byte = `UEFR_ZERO8;
    endcase
  end

  // Ack one cycle after the request, dropped in the cycle after it
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= `UEFR_ZERO32;
    end else begin
      WB_ACK_O <= req;
      if (req) begin
        WB_DAT_O <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ==========================================
  // Software masks for the flag register
  // Flag register: zero clears, one sets; error summary is masked out
  always_comb begin
    sw_set = '0;
    sw_clr = '0;
    if (wr_flags) begin
      sw_set = WB_DAT_I[6:0];
      sw_clr = ~WB_DAT_I[6:0];
    end
    if (wr_clr) begin
      sw_clr = sw_clr | WB_DAT_I[6:0];
    end
    sw_set[`UEFR_B_UERR] = 1'b0;
    sw_clr[`UEFR_B_UERR] = 1'b0;
  end

  // ==========================================
  // Activity detection runs off the plain clock, so it works in suspend
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      lines_dp_r <= 1'b0;
      lines_dm_r <= 1'b0;
      lines_ok_r <= 1'b0;
    end else begin
      lines_dp_r <= LINE_DP_I;
      lines_dm_r <= LINE_DM_I;
      lines_ok_r <= 1'b1;
    end
  end

  // First sample after reset has nothing to compare against
  assign actv_evt = lines_ok_r && ((LINE_DP_I != lines_dp_r) || (LINE_DM_I != lines_dm_r));

  // ==========================================
  // Idle detector; the count freezes while the engine is unclocked
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      idle_state_r <= uefr_pkg::UEFR_IDLE_BUSY;
      idle_cnt_r   <= '0;
    end else begin
      case (idle_state_r)
        uefr_pkg::UEFR_IDLE_BUSY: begin
          idle_cnt_r <= '0;
          if (BUS_IDLE_I && !susp) begin
            idle_state_r <= uefr_pkg::UEFR_IDLE_COUNT;
          end
        end
        uefr_pkg::UEFR_IDLE_COUNT: begin
          if (!BUS_IDLE_I) begin
            idle_state_r <= uefr_pkg::UEFR_IDLE_BUSY;
          end else if (idle_hit) begin
            idle_state_r <= uefr_pkg::UEFR_IDLE_SEEN;
          end else if (!susp) begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
          end
        end
        uefr_pkg::UEFR_IDLE_SEEN: begin
          // One flag per idle stretch, rearmed by bus traffic
          if (!BUS_IDLE_I) begin
            idle_state_r <= uefr_pkg::UEFR_IDLE_BUSY;
          end
        end
        default: begin
          idle_state_r <= uefr_pkg::UEFR_IDLE_BUSY;
        end
      endcase
    end
  end

  // The first counted cycle is the one entering COUNT, so reach N-1
  assign idle_hit = (idle_state_r == uefr_pkg::UEFR_IDLE_COUNT) && BUS_IDLE_I && !susp
                    && (idle_cnt_r == IW'(IDLE_CYCLES - 1));

  // ==========================================
  // Transfer status queue
  // Completions are dropped while suspended; the source must honour ready
  assign trn_push = TRN_DONE_I && !susp && TRN_READY_O;
  // Pop when software takes a set done flag down
  assign trn_pop  = flags_r[`UEFR_B_TRN] && sw_clr[`UEFR_B_TRN];

  uefr_stat_queue #(
    .WIDTH (8),
    .DEPTH (QUEUE_DEPTH)
  ) u_stat_queue (
    .clk_i   (CLK_SYS_I),
    .reset_i (RESET_I),
    .push_i  (trn_push),
    .data_i  (TRN_STAT_I),
    .ready_o (TRN_READY_O),
    .pop_i   (trn_pop),
    .head_o  (q_head),
    .count_o (q_count)
  );

  // ==========================================
  // Hardware set requests; suspend gates all but activity and the done re-raise after a pop
  always_comb begin
    hw_set                = '0;
    hw_set[`UEFR_B_SOF]   = SOF_EVT_I && !susp;
    hw_set[`UEFR_B_STALL] = STALL_SENT_I && !susp;
    hw_set[`UEFR_B_IDLE]  = idle_hit;
    // Another waiting record re-raises the flag after a pop
    hw_set[`UEFR_B_TRN]   = trn_push || (trn_pop && (q_count > CW'(1)));
    hw_set[`UEFR_B_ACTV]  = actv_evt;
    hw_set[`UEFR_B_URST]  = BUS_RESET_I && !susp;
  end

  // Set wins over clear; summary bit follows latched errors only
  always_comb begin
    flags_nxt = (flags_r & ~sw_clr) | sw_set | hw_set;
    flags_nxt[`UEFR_B_UERR] = |err_flags_r;
  end

  // Event flag bank
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      flags_r <= `UEFR_ZERO7;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================
  // Error latch: only enabled conditions land, set wins over clear
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      err_flags_r <= `UEFR_ZERO8;
    end else begin
      err_flags_r <= (err_flags_r & ~((wr_fire && (WB_ADR_I == `UEFR_OFS_ERR_FLAGS))
                                      ? WB_DAT_I[7:0] : `UEFR_ZERO8))
                     | (susp ? `UEFR_ZERO8 : (ERR_EVT_I & err_en_r));
    end
  end

  // ==========================================
  // Software-owned configuration registers
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      enables_r <= `UEFR_ZERO7;
      err_en_r  <= `UEFR_ZERO8;
      control_r <= `UEFR_ZERO8;
    end else if (wr_fire) begin
      if (WB_ADR_I == `UEFR_OFS_ENABLES) begin
        enables_r <= WB_DAT_I[6:0];
      end
      if (WB_ADR_I == `UEFR_OFS_ERR_EN) begin
        err_en_r <= WB_DAT_I[7:0];
      end
      if (WB_ADR_I == `UEFR_OFS_CONTROL) begin
        control_r <= WB_DAT_I[7:0];
      end
    end
  end

  // Function address; a bus reset beats a same-cycle write
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      FUNC_ADDR_O <= `UEFR_ZERO7;
    end else if (hw_set[`UEFR_B_URST]) begin
      FUNC_ADDR_O <= `UEFR_ZERO7;
    end else if (wr_fire && (WB_ADR_I == `UEFR_OFS_FUNC_ADDR)) begin
      FUNC_ADDR_O <= WB_DAT_I[6:0];
    end
  end

  // ==========================================
  // Interrupt outputs, both registered
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      USB_IRQ_REQ_O <= 1'b0;
      IRQ_O         <= 1'b0;
      SUSPEND_O     <= 1'b0;
    end else begin
      USB_IRQ_REQ_O <= |flags_nxt;
      IRQ_O         <= |(flags_r & enables_r);
      SUSPEND_O     <= susp;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);

  // A software-forced done flag with nothing queued pops nothing
  sequence s_done_ack;
    trn_pop && !trn_push && (q_count != '0);
  endsequence

  sequence s_queue_step;
    ##1 (q_count == $past(q_count) - CW'(1));
  endsequence

  a_enable_gate: assert property (IRQ_O == $past(|(flags_r & enables_r)))
    else $error("interrupt output disagrees with enabled flags");

  a_request_or: assert property (USB_IRQ_REQ_O == |flags_r)
    else $error("request flag is not the OR of all flags");

  a_flag_sticky: assert property (!wr_flags && !wr_clr |=>
    (flags_r[`UEFR_B_SOF:`UEFR_B_ACTV] & $past(flags_r[`UEFR_B_SOF:`UEFR_B_ACTV]))
    == $past(flags_r[`UEFR_B_SOF:`UEFR_B_ACTV]))
    else $error("a set flag fell without a software clear");

  a_sw_force: assert property (wr_flags && WB_DAT_I[`UEFR_B_SOF] |=> flags_r[`UEFR_B_SOF])
    else $error("software set of a flag was lost");

  a_suspend_block: assert property (susp && !wr_flags |=>
    !$rose(flags_r[`UEFR_B_STALL]) && !$rose(flags_r[`UEFR_B_SOF])
    && !$rose(flags_r[`UEFR_B_URST]))
    else $error("engine event raised a flag while suspended");

  a_bit7_zero: assert property (WB_ACK_O && $past(WB_ADR_I) == `UEFR_OFS_FLAGS |-> !WB_DAT_O[7])
    else $error("unimplemented flag bit read as one");

  a_stall_set: assert property (STALL_SENT_I && !susp |=> flags_r[`UEFR_B_STALL])
    else $error("stall sent did not set the stall flag");

  a_idle_time: assert property (idle_hit |->
    idle_cnt_r == IW'(IDLE_CYCLES - 1) && $past(BUS_IDLE_I))
    else $error("idle flag raised before the idle time");

  a_done_set: assert property (trn_push |=> flags_r[`UEFR_B_TRN] && q_count != '0)
    else $error("completion did not set the done flag");

  a_activity: assert property (actv_evt |=> flags_r[`UEFR_B_ACTV])
    else $error("line activity missed");

  a_err_enabled: assert property (
    |(err_flags_r & ~$past(err_flags_r) & ~$past(err_en_r)) == 1'b0)
    else $error("disabled error condition latched");

  a_err_readonly: assert property (flags_r[`UEFR_B_UERR] == $past(|err_flags_r))
    else $error("error summary moved without an error");

  a_reset_addr: assert property (BUS_RESET_I && !susp |=>
    FUNC_ADDR_O == `UEFR_ZERO7 && flags_r[`UEFR_B_URST])
    else $error("bus reset did not clear the address");

  a_queue_advance: assert property (s_done_ack |-> s_queue_step)
    else $error("clearing the done flag did not advance the queue");

  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");

endmodule : uefr_top

// File: verification/test_usb_event_flag_register.sv
// Self-checking bench for the USB event flag block
module test_usb_event_flag_register;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Signals
  logic        clk, rst, cyc, stb, we, ack;      // Clock, reset, bus control
  logic [7:0]  adr, stat, err, tstat, errv;      // Address and event payloads
  logic [3:0]  sel;                              // Byte selects
  logic [31:0] dati, dato, rdat;                 // Bus data
  logic [6:0]  cmd, faddr;                       // Event commands, address out
  logic        idle, sof, stall, bidle, tdone;   // Engine event lines
  logic        trdy, breset, dp, dm, susp, ureq, irq;
  int          fails, checked;                   // Report counters

  // ==========================================
  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================
  // Block under test, idle time shortened to 20 cycles
  uefr_top #(.IDLE_CYCLES(20), .QUEUE_DEPTH(4)) dut (
    .CLK_SYS_I(clk), .RESET_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dati),
    .WB_DAT_O(dato), .WB_ACK_O(ack), .SOF_EVT_I(sof), .STALL_SENT_I(stall),
    .BUS_IDLE_I(bidle), .TRN_DONE_I(tdone), .TRN_STAT_I(tstat),
    .TRN_READY_O(trdy), .BUS_RESET_I(breset), .ERR_EVT_I(errv),
    .LINE_DP_I(dp), .LINE_DM_I(dm), .SUSPEND_O(susp), .FUNC_ADDR_O(faddr),
    .USB_IRQ_REQ_O(ureq), .IRQ_O(irq));

  // Far-side engine model
  uefr_engine_model eng (
    .clk_i(clk), .reset_i(rst), .fire_i(cmd), .idle_i(idle), .err_i(err),
    .stat_i(stat), .trn_ready_i(trdy), .sof_o(sof), .stall_o(stall),
    .idle_o(bidle), .trn_done_o(tdone), .trn_stat_o(tstat),
    .bus_reset_o(breset), .err_o(errv), .dp_o(dp), .dm_o(dm));

  // ==========================================
  // Helpers
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // Wait n edges, then step past them so outputs are settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; waits for ack with a bound, no fixed latency assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dati <= d; sel <= sel;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      fails++;
      $display("ERROR %0t no bus answer", $time);
      end_sim();
    end
    rdat = dato;  // Taken at the ack edge only
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd

  // Command one engine event, then let it reach the flags
  task automatic fire(input logic [6:0] f, input logic [7:0] s = 8'h00,
                      input logic [7:0] e = 8'h00);
    @(posedge clk);
    cmd <= f; stat <= s; err <= e;
    @(posedge clk);
    cmd <= 7'h00;
    wt(4);
  endtask : fire

  // ==========================================
  // Scenarios
  task automatic t_reset;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    chk(irq, 32'h0);
    chk(ureq, 32'h0);
    chk(trdy, 32'h1);
  endtask : t_reset

  // Software sets all, summary bit and bit seven stay clear
  task automatic t_soft;
    wb(1'b1, 8'h00, 32'hff);
    rd(8'h00, 32'h7d);
    chk(ureq, 32'h1);
    wb(1'b1, 8'h00, 32'h0);
    rd(8'h00, 32'h0);
  endtask : t_soft

  // SOF, stall, done, activity and bus reset events each set their own bit, which then sticks
  task automatic t_events;
    int bits[5] = '{6, 5, 3, 2, 0};
    foreach (bits[i]) begin
      fire(7'h01 << bits[i]);
      wt(6);
      rd(8'h00, 32'h1 << bits[i]);
      wb(1'b1, 8'h00, 32'h0);
    end
  endtask : t_events

  task automatic t_irq;
    fire(7'h40);
    wb(1'b1, 8'h04, 32'h40);
    wt(2);
    chk(irq, 32'h1);
    wb(1'b1, 8'h04, 32'h0);
    wt(2);
    chk(irq, 32'h0);
    chk(ureq, 32'h1);
    wb(1'b1, 8'h1c, 32'h40);
    rd(8'h00, 32'h0);
    chk(ureq, 32'h0);
  endtask : t_irq

  // Masked error ignored; enabled one sets summary, a flag write cannot clear it, an error-flag write does
  task automatic t_err;
    fire(7'h02, 8'h00, 8'h05);
    rd(8'h00, 32'h0);
    wb(1'b1, 8'h08, 32'h04);
    fire(7'h02, 8'h00, 8'h05);
    rd(8'h00, 32'h02);
    wb(1'b1, 8'h00, 32'h0);
    rd(8'h00, 32'h02);
    wb(1'b1, 8'h0c, 32'hff);
    wb(1'b1, 8'h08, 32'h0);
    rd(8'h00, 32'h0);
  endtask : t_err

  // Idle must last the whole count; first read samples one edge too early
  task automatic t_idle;
    @(posedge clk);
    idle <= 1'b1;
    wt(19);
    rd(8'h00, 32'h0);
    rd(8'h00, 32'h10);
    @(posedge clk);
    idle <= 1'b0;
    wb(1'b1, 8'h00, 32'h0);
  endtask : t_idle

  // Suspended: only activity gets through, nothing queued
  task automatic t_susp;
    wb(1'b1, 8'h10, 32'h02);
    wt(2);
    chk(susp, 32'h1);
    fire(7'h69, 8'h33);
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h0);
    fire(7'h04);
    rd(8'h00, 32'h04);
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
  endtask : t_susp

  task automatic t_addr;
    wb(1'b1, 8'h18, 32'h55);
    chk(faddr, 32'h55);
    fire(7'h01);
    rd(8'h00, 32'h01);
    rd(8'h18, 32'h0);
    chk(faddr, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
  endtask : t_addr

  // Queue filled to its depth; each clear of done shows the next record
  task automatic t_queue;
    logic [7:0] recs[4] = '{8'h21, 8'h42, 8'h63, 8'h84};
    foreach (recs[i]) begin
      fire(7'h08, recs[i]);
    end
    chk(trdy, 32'h0);
    foreach (recs[i]) begin
      rd(8'h14, {24'h0, recs[i]});
      rd(8'h00, 32'h08);
      wb(1'b1, 8'h00, 32'h0);
    end
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h0);
    chk(trdy, 32'h1);
  endtask : t_queue

  // Low byte deselected: write acked, stores nothing; unmapped place reads zero
  task automatic t_unmap;
    @(posedge clk);
    sel <= 4'he;
    wb(1'b1, 8'h00, 32'hff);
    sel <= 4'hf;
    rd(8'h00, 32'h0);
    wb(1'b1, 8'h20, 32'hff);
    rd(8'h20, 32'h0);
    rd(8'h00, 32'h0);
  endtask : t_unmap

  // ==========================================
  // Main sequence
  initial begin
    fails = 0; checked = 0; rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; sel = 4'hf; dati = 32'h0; cmd = 7'h00; idle = 1'b0;
    err = 8'h00; stat = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_soft();
    t_events();
    t_irq();
    t_err();
    t_idle();
    t_susp();
    t_addr();
    t_queue();
    t_unmap();
    end_sim();
  end
endmodule : test_usb_event_flag_register

// File: verification/uefr_engine_model.sv
// Behavioural serial engine that raises events toward the flag block
module uefr_engine_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Bench commands, one bit per flag position
  input  wire logic [6:0] fire_i,
  input  wire logic       idle_i,
  input  wire logic [7:0] err_i,
  input  wire logic [7:0] stat_i,
  input  wire logic       trn_ready_i,
  // Event lines toward the block
  output logic            sof_o,
  output logic            stall_o,
  output logic            idle_o,
  output logic            trn_done_o,
  output logic [7:0]      trn_stat_o,
  output logic            bus_reset_o,
  output logic [7:0]      err_o,
  output logic            dp_o,
  output logic            dm_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Event pulses, each one cycle long
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sof_o       <= 1'b0;
      stall_o     <= 1'b0;
      idle_o      <= 1'b0;
      trn_done_o  <= 1'b0;
      trn_stat_o  <= 8'h00;
      bus_reset_o <= 1'b0;
      err_o       <= 8'h00;
      dp_o        <= 1'b1;  // Lines rest in the J state
      dm_o        <= 1'b0;
    end else begin
      sof_o       <= fire_i[6];
      stall_o     <= fire_i[5];
      idle_o      <= idle_i;  // Level, held by the bench
      trn_done_o  <= fire_i[3] & trn_ready_i;
      trn_stat_o  <= stat_i;
      bus_reset_o <= fire_i[0];
      err_o       <= fire_i[1] ? err_i : 8'h00;
      // Activity flips both lines, J to K and back
      if (fire_i[2]) begin
        dp_o <= ~dp_o;
        dm_o <= ~dm_o;
      end
    end
  end
endmodule : uefr_engine_model
